// *** include/mcd_defines.svh ***
// Purpose: constants for the microcore configuration decoder
// Assumes: 16-bit instruction words, 32-bit bus data
// Notes:   offsets are byte addresses on the register bus
`ifndef MCD_DEFINES_SVH
`define MCD_DEFINES_SVH
// register byte offsets
`define MCD_OFF_RIGHTS 8'h00
`define MCD_OFF_STATUS 8'h04
`define MCD_OFF_CTRL   8'h08
// opcode matches: (word & mask) == pattern
`define MCD_MSK_SHIFT  16'hff80
`define MCD_PAT_SHRSI  16'h2780
`define MCD_PAT_SHRI   16'h2c80
`define MCD_MSK_SEL1   16'hfffe
`define MCD_PAT_SLAB   16'h360a
`define MCD_PAT_SLSA   16'h3608
`define MCD_MSK_SLFBK  16'hfff8
`define MCD_PAT_SLFBK  16'h3640
`define MCD_MSK_STAB   16'hffc0
`define MCD_PAT_STAB   16'h3400
`define MCD_MSK_STADC  16'hfff8
`define MCD_PAT_STADC  16'h3568
`define MCD_MSK_STAL   16'hfffc
`define MCD_PAT_STAL   16'h357c
`define MCD_MSK_STCRB  16'hffe8
`define MCD_PAT_STCRB  16'h3740
// instruction field positions
`define MCD_IMM_LSB    3
`define MCD_OP1_LSB    0
`define MCD_REF_BIT    2
`define MCD_ADCM_BIT   2
`define MCD_LVL_BIT    4
`define MCD_CRB_BASE   8
// reset values
`define MCD_RST_ARITH  2'h2
`define MCD_RST_CTRL   16'h0000
`define MCD_RST_RIGHTS 8'h00
// status bit positions
`define MCD_ST_SB      16
`define MCD_ST_MO      17
`define MCD_ST_ML      18
`define MCD_ST_BUSY    19
`endif

// *** include/mcd_pkg.sv ***
// Purpose: types of the microcore configuration decoder
// Assumes: nothing beyond the defines header
// Notes:   settings travel as one packed struct
package mcd_pkg;
  typedef enum logic [1:0] {
    MCD_SIGNED_WRAP, MCD_SIGNED_SAT, MCD_UNSIGNED_WRAP, MCD_UNSIGNED_SAT
  } mcd_arith_t;
  typedef enum logic {MCD_IDLE, MCD_SHIFTING} mcd_state_t;
  typedef struct packed {
    logic       base_from_index;
    logic [5:0] index_base_value;
    logic       spi_from_index;
    logic       fb_ref_battery;
    logic       auto_diag_on;
    logic [3:0] conversion_enable;
    mcd_arith_t arith_mode;
    logic [15:0] control_reg;
  } mcd_cfg_t;
  typedef struct packed {
    logic shifted_out_flag;
    logic shift_overflow_flag;
    logic precision_loss_flag;
  } mcd_flags_t;
endpackage

// *** sim/mcd_chk_assertions.sv ***
// Purpose: port checks for the configuration decoder
// Assumes: one clock, synchronous reset
// Notes:   bound into every mcd_decoder
`timescale 1ns/1ps
`include "mcd_defines.svh"
module mcd_chk
(
  // clock and instruction side
  input wire logic                i_clk_sys,
  input wire logic                i_rst,
  input wire logic                i_ce,
  input wire logic                i_instr_valid,
  input wire logic [15:0]         i_instr,
  input wire logic [15:0]         i_alu_operand,
  // watched outputs
  input wire logic                o_busy,
  input wire logic                o_wb_valid,
  input wire logic [15:0]         o_wb_data,
  input wire mcd_pkg::mcd_cfg_t   o_cfg,
  input wire mcd_pkg::mcd_flags_t o_flags,
  input wire logic                o_arith_signed
);
  import mcd_pkg::*;
  logic        take, shr_s, shr_u, sgn_q, sb_exp;
  logic [15:0] op_q, w_q, lost, exp_d;
  logic [3:0]  imm_q;
  // decode of the word being taken
  assign take   = i_ce && i_instr_valid && !o_busy;
  assign shr_s  = (i_instr & `MCD_MSK_SHIFT) == `MCD_PAT_SHRSI;
  assign shr_u  = (i_instr & `MCD_MSK_SHIFT) == `MCD_PAT_SHRI;
  // expected shift outcome from captured operands
  assign lost   = op_q & ((16'h1 << imm_q) - 16'h1);
  assign sb_exp = (imm_q != 4'h0) && op_q[imm_q - 4'h1];
  assign exp_d  = sgn_q ? 16'($signed(op_q) >>> imm_q) : op_q >> imm_q;
  // last word and shift operands
  always_ff @(posedge i_clk_sys)
  begin
    w_q <= i_instr;
    if (take && (shr_s || shr_u))
    begin
      op_q  <= i_alu_operand;
      imm_q <= i_instr[6:3];
      sgn_q <= shr_s;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  property p_len;
    take && shr_s && i_instr[6:3] == 4'h2
      |=> o_busy [*2] ##1 (!o_busy && o_wb_valid);
  endproperty
  a_len: assert property (p_len)
    else $error("shift length wrong");
  property p_data;
    o_wb_valid |-> o_wb_data == exp_d;
  endproperty
  a_data: assert property (p_data)
    else $error("shift result wrong");
  property p_sflag;
    o_wb_valid |-> o_flags.shifted_out_flag == sb_exp
      && o_flags.shift_overflow_flag == (sgn_q && lost != 16'h0);
  endproperty
  a_sflag: assert property (p_sflag)
    else $error("shift flags wrong");
  property p_uflag;
    o_wb_valid && !sgn_q |-> o_flags.precision_loss_flag == (lost != 16'h0);
  endproperty
  a_uflag: assert property (p_uflag)
    else $error("precision loss flag wrong");
  property p_slab;
    take && (i_instr & `MCD_MSK_SEL1) == `MCD_PAT_SLAB
      |=> o_cfg.base_from_index == w_q[0];
  endproperty
  a_slab: assert property (p_slab)
    else $error("base source not set");
  property p_stab;
    take && (i_instr & `MCD_MSK_STAB) == `MCD_PAT_STAB
      |=> o_cfg.index_base_value == w_q[5:0];
  endproperty
  a_stab: assert property (p_stab)
    else $error("base value not loaded");
  property p_slsa;
    take && (i_instr & `MCD_MSK_SEL1) == `MCD_PAT_SLSA
      |=> o_cfg.spi_from_index == w_q[0];
  endproperty
  a_slsa: assert property (p_slsa)
    else $error("serial source not set");
  property p_stal;
    take && (i_instr & `MCD_MSK_STAL) == `MCD_PAT_STAL
      |=> o_cfg.arith_mode == w_q[1:0] && o_arith_signed == !w_q[1];
  endproperty
  a_stal: assert property (p_stal)
    else $error("arith mode not set");
  property p_crb;
    take && (i_instr & `MCD_MSK_STCRB) == `MCD_PAT_STCRB
      |=> o_cfg.control_reg[{1'b1, w_q[2:0]}] == w_q[4];
  endproperty
  a_crb: assert property (p_crb)
    else $error("control bit not written");
  property p_nostall;
    take && !shr_s && !shr_u |=> !o_busy;
  endproperty
  a_nostall: assert property (p_nostall)
    else $error("setting stalled the core");
endmodule
bind mcd_decoder mcd_chk u_mcd_chk
(
  .i_clk_sys, .i_rst, .i_ce, .i_instr_valid, .i_instr, .i_alu_operand,
  .o_busy, .o_wb_valid, .o_wb_data, .o_cfg, .o_flags, .o_arith_signed
);

// *** sim/mcd_decoder_tb_top.sv ***
// Purpose: self-checking bench for the configuration decoder
// Assumes: zero-wait bus slave, program model on the word port
// Notes:   expected values stepped out bit by bit in the bench
`timescale 1ns/1ps
module mcd_decoder_tb_top;
  import mcd_pkg::*;
  logic        i_clk_sys, i_rst, i_ce, i_instr_valid, o_busy, o_wb_valid;
  logic [15:0] i_instr, i_alu_operand, i_alu_index_reg, o_wb_data, v, ctl;
  logic [2:0]  o_wb_sel;
  mcd_cfg_t    o_cfg;
  mcd_flags_t  o_flags;
  logic [5:0]  o_data_base;
  logic        o_arith_signed, o_arith_saturate, hsel, hwrite, hreadyout;
  logic        hresp, rdy_q, sb, lo, dg;
  logic [1:0]  htrans;
  logic [3:0]  cv;
  logic [31:0] haddr, hwdata, hrdata, rd_q, rd;
  int          errors, cmp_count, i, k, n;
  logic [15:0] sw [4] = '{16'h2793, 16'h27fa, 16'h2781, 16'h2ca5};
  logic [15:0] so [4] = '{16'h8005, 16'h7fff, 16'h1234, 16'h80f8};
  logic [15:0] fw [4] = '{16'h3647, 16'h3640, 16'h3641, 16'h3646};
  mcd_decoder u_mcd_decoder
  (
    .i_clk_sys, .i_rst, .i_ce, .i_instr_valid, .i_instr, .i_alu_operand,
    .i_alu_index_reg, .o_busy, .o_wb_valid, .o_wb_sel, .o_wb_data, .o_cfg,
    .o_flags, .o_data_base, .o_arith_signed, .o_arith_saturate, .hsel,
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata
  );
  mcd_prog_model u_mcd_prog_model
  (
    .i_clk_sys, .i_busy(o_busy), .o_valid(i_instr_valid), .o_instr(i_instr),
    .o_operand(i_alu_operand)
  );
  // 40 MHz clock
  initial
  begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  // bus answer as seen at each edge
  always @(posedge i_clk_sys)
  begin
    rdy_q <= hreadyout;
    rd_q  <= hrdata;
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick();
    @(posedge i_clk_sys);
    #1;
  endtask
  // bounded wait for hready at an edge
  task automatic wait_rdy();
    int m;
    for (m = 0; m < 50; m++)
    begin
      tick();
      if (rdy_q)
        return;
    end
    errors++;
    wrap_up();
  endtask
  // one single word transfer
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = rd_q;
    chk("hresp", 32'h0, hresp);
  endtask
  task automatic put(input logic [15:0] w);
    u_mcd_prog_model.issue(w, 16'h0000);
  endtask
  // main sequence
  initial
  begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    i_alu_index_reg = 16'h0015;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    errors = 0;
    cmp_count = 0;
    repeat (10) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    #1;
    bus(1'b0, 32'h4, 32'h0);
    chk("status", 32'h2, rd);
    bus(1'b1, 32'hc, 32'hffffffff);
    bus(1'b0, 32'hc, 32'h0);
    chk("unmapped", 32'h0, rd);
    // shifts: signed, full range, zero, unsigned
    for (i = 0; i < 4; i++)
    begin
      u_mcd_prog_model.issue(sw[i], so[i]);
      for (n = 0; n < 40 && !o_wb_valid; n++)
        tick();
      if (n == 40)
      begin
        errors++;
        wrap_up();
      end
      v = so[i];
      sb = 1'b0;
      lo = 1'b0;
      for (k = 0; k < sw[i][6:3]; k++)
      begin
        sb = v[0];
        lo = lo | v[0];
        v = sw[i][9] ? {v[15], v[15:1]} : v >> 1;
      end
      chk("cycles", sw[i][6:3], n);
      chk("data", v, o_wb_data);
      chk("sel", sw[i][2:0], o_wb_sel);
      chk("shifted", sb, o_flags.shifted_out_flag);
      chk("ovf", sw[i][9] & lo, o_flags.shift_overflow_flag);
      chk("loss", !sw[i][9] & lo, o_flags.precision_loss_flag);
    end
    // base and serial address sources
    put(16'h342a);
    chk("base", 32'h2a, o_data_base);
    put(16'h360b);
    chk("base_ir", 32'h15, o_data_base);
    put(16'h3609);
    chk("spi_ir", 32'h1, o_cfg.spi_from_index);
    put(16'h3608);
    chk("spi_reg", 32'h0, o_cfg.spi_from_index);
    // every arithmetic mode
    for (i = 0; i < 4; i++)
    begin
      put(16'h357c | 16'(i[1:0]));
      chk("mode", i[1:0], o_cfg.arith_mode);
      chk("signed", !i[1], o_arith_signed);
      chk("sat", i[0], o_arith_saturate);
    end
    // feedback refused without rights, then every diag code
    put(16'h3647);
    chk("ref_refused", 32'h0, o_cfg.fb_ref_battery);
    chk("busy", 32'h0, o_busy);
    bus(1'b1, 32'h0, 32'h1);
    dg = 1'b0;
    for (i = 0; i < 4; i++)
    begin
      put(fw[i]);
      if (fw[i][1])
        dg = fw[i][0];
      chk("ref", fw[i][2], o_cfg.fb_ref_battery);
      chk("diag", dg, o_cfg.auto_diag_on);
    end
    // conversion: refused, set each target, clear each target
    cv = 4'h0;
    for (i = 0; i < 12; i++)
    begin
      if (i == 4)
        bus(1'b1, 32'h0, 32'hf1);
      put({13'h6ad, i < 8, i[1:0]});
      if (i >= 4)
        cv[i[1:0]] = (i < 8);
      chk("conv", cv, o_cfg.conversion_enable);
    end
    // control bits 8 to 15 written one at a time
    bus(1'b1, 32'h8, 32'h5a5a);
    ctl = 16'h5a5a;
    for (i = 0; i < 8; i++)
    begin
      put(16'h3740 | (i[0] ? 16'h0 : 16'h10) | 16'(i[2:0]));
      ctl[8 + i] = !i[0];
      chk("ctrl", ctl, o_cfg.control_reg);
    end
    // clock enable low: the word is not taken
    i_ce <= 1'b0;
    put(16'h3740);
    chk("ce_hold", ctl, o_cfg.control_reg);
    i_ce <= 1'b1;
    bus(1'b0, 32'h8, 32'h0);
    chk("ctrl_rd", ctl, rd);
    wrap_up();
  end
endmodule

// *** sim/mcd_prog_model.sv ***
// Purpose: microcode program stand-in for the instruction port
// Assumes: issue is called just after a rising edge
// Notes:   one word per call, never offered while a shift runs
`timescale 1ns/1ps
module mcd_prog_model
(
  // clock and core state
  input  wire logic   i_clk_sys,
  input  wire logic   i_busy,
  // instruction lines
  output logic        o_valid,
  output logic [15:0] o_instr,
  output logic [15:0] o_operand
);
  // idle lines at start
  initial
  begin
    o_valid   = 1'b0;
    o_instr   = 16'h0000;
    o_operand = 16'h0000;
  end
  // offer one word for one take edge
  task automatic issue(input logic [15:0] w, input logic [15:0] op);
    int n;
    @(posedge i_clk_sys);
    #1;
    for (n = 0; n < 64 && i_busy; n++)
    begin
      @(posedge i_clk_sys);
      #1;
    end
    if (i_busy)
    begin
      mcd_decoder_tb_top.errors++;
      mcd_decoder_tb_top.wrap_up();
    end
    o_valid   <= 1'b1;
    o_instr   <= w;
    o_operand <= op;
    @(posedge i_clk_sys);
    #1;
    // released lines show the inverse, not a stale copy
    o_valid   <= 1'b0;
    o_instr   <= ~w;
    o_operand <= ~op;
  endtask
endmodule

// *** src/mcd_decoder.sv ***
// Purpose: decode and execute microcore configuration instructions
// Assumes: instruction words come from logic on the same clock
// Notes:   registers reached over an AHB-Lite slave, zero wait
`timescale 1ns/1ps
`include "mcd_defines.svh"

// Functional notes
// - signed immediate right shift keeps the sign bit of the target
// - signed immediate shift takes as many cycles as its immediate
// - shift amount is the 4-bit immediate field of the word
// - signed shift updates shifted-out and shift-overflow flags
// - base select: 0 dedicated base register, 1 ALU index register
// - base load writes the 6-bit indexed addressing base register
// - serial address select: 0 dedicated register, 1 index register
// - feedback select sets shared drain reference: 0 boost, 1 battery
// - diagnosis field: 00 keep, 01 unused, 10 off, 11 on
// - feedback select applies only with output drive rights
// - conversion mode per current block: 0 compare, 1 convert
// - target field picks core and channel of the current block
// - conversion mode applies only with current block access rights
// - arithmetic mode codes 00 to 11, reset value 10
// - overflow flagged in all modes, clamping only when saturating
// - arithmetic mode held in two condition register mode bits
// - control bit select 000 to 111 picks bits 8 to 15
// - level 0 low, 1 high; only the selected bit changes
// - unsigned right shift gives shifted-out and precision-loss flags
module mcd_decoder
(
  // clock, reset, enable
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst,
  input  wire logic               i_ce,
  // instruction stream
  input  wire logic               i_instr_valid,
  input  wire logic [15:0]        i_instr,
  input  wire logic [15:0]        i_alu_operand,
  input  wire logic [15:0]        i_alu_index_reg,
  output logic                    o_busy,
  // shift write back
  output logic                    o_wb_valid,
  output logic [2:0]              o_wb_sel,
  output logic [15:0]             o_wb_data,
  // settings and flags
  output mcd_pkg::mcd_cfg_t       o_cfg,
  output mcd_pkg::mcd_flags_t     o_flags,
  output logic [5:0]              o_data_base,
  output logic                    o_arith_signed,
  output logic                    o_arith_saturate,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata
);
  import mcd_pkg::*;

  // opcode match helper
  function automatic logic op_is(input logic [15:0] w,
                                 input logic [15:0] msk,
                                 input logic [15:0] pat);
    op_is = (w & msk) == pat;
  endfunction

  // one right shift step, sign kept when arithmetic
  function automatic logic [15:0] shr1(input logic [15:0] v,
                                       input logic        arith);
    shr1 = {arith & v[15], v[15:1]};
  endfunction

  mcd_state_t  state_reg;
  mcd_cfg_t    cfg_reg;
  mcd_flags_t  flags_reg;
  logic [15:0] sh_val_reg;
  logic [3:0]  sh_cnt_reg;
  logic        sh_arith_reg;
  logic        sh_loss_reg;
  logic        sh_last_reg;
  logic [2:0]  sh_sel_reg;
  logic        wb_valid_reg;
  logic [15:0] wb_data_reg;
  logic [2:0]  wb_sel_reg;
  logic [7:0]  rights_reg;
  logic [31:0] rdata_reg;
  logic        bus_wr_reg;
  logic [7:0]  bus_addr_reg;

  logic        take;
  logic        is_shrsi;
  logic        is_shri;
  logic        is_slab;
  logic        is_slsa;
  logic        is_slfbk;
  logic        is_stab;
  logic        is_stadc;
  logic        is_stal;
  logic        is_stcrb;
  logic [3:0]  imm;
  logic [15:0] sh_val_next;
  logic [1:0]  tgt;
  logic        drive_ok;
  logic        block_ok;
  logic        bus_addr_ok;
  logic        bus_wr_ctrl;
  logic        bus_wr_rights;
  logic [31:0] status_word;

  // instruction decode, only when idle
  assign take     = i_instr_valid & (state_reg == MCD_IDLE);
  assign is_shrsi = take & op_is(i_instr, `MCD_MSK_SHIFT, `MCD_PAT_SHRSI);
  assign is_shri  = take & op_is(i_instr, `MCD_MSK_SHIFT, `MCD_PAT_SHRI);
  assign is_slab  = take & op_is(i_instr, `MCD_MSK_SEL1, `MCD_PAT_SLAB);
  assign is_slsa  = take & op_is(i_instr, `MCD_MSK_SEL1, `MCD_PAT_SLSA);
  assign is_slfbk = take & op_is(i_instr, `MCD_MSK_SLFBK, `MCD_PAT_SLFBK);
  assign is_stab  = take & op_is(i_instr, `MCD_MSK_STAB, `MCD_PAT_STAB);
  assign is_stadc = take & op_is(i_instr, `MCD_MSK_STADC, `MCD_PAT_STADC);
  assign is_stal  = take & op_is(i_instr, `MCD_MSK_STAL, `MCD_PAT_STAL);
  assign is_stcrb = take & op_is(i_instr, `MCD_MSK_STCRB, `MCD_PAT_STCRB);

  // immediate and target fields
  assign imm = i_instr[`MCD_IMM_LSB +: 4];
  assign tgt = i_instr[1:0];

  // access checks against software-granted rights
  assign drive_ok = rights_reg[0];
  assign block_ok = rights_reg[4 + tgt];

  // one step of the running shift
  assign sh_val_next = shr1(sh_val_reg, sh_arith_reg);

  // shift sequencer
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      state_reg    <= MCD_IDLE;
      sh_val_reg   <= 16'h0000;
      sh_cnt_reg   <= 4'h0;
      sh_arith_reg <= 1'b0;
      sh_loss_reg  <= 1'b0;
      sh_last_reg  <= 1'b0;
      sh_sel_reg   <= 3'h0;
    end
    else if (i_ce)
    begin
      unique case (state_reg)
        MCD_IDLE:
        begin
          if ((is_shrsi | is_shri) && (imm != 4'h0))
          begin
            state_reg    <= MCD_SHIFTING;
            sh_val_reg   <= i_alu_operand;
            sh_cnt_reg   <= imm;
            sh_arith_reg <= is_shrsi;
            sh_loss_reg  <= 1'b0;
            sh_last_reg  <= 1'b0;
            sh_sel_reg   <= i_instr[`MCD_OP1_LSB +: 3];
          end
        end
        MCD_SHIFTING:
        begin
          sh_val_reg  <= sh_val_next;
          sh_last_reg <= sh_val_reg[0];
          sh_loss_reg <= sh_loss_reg | sh_val_reg[0];
          sh_cnt_reg  <= sh_cnt_reg - 4'h1;
          if (sh_cnt_reg == 4'h1)
          begin
            state_reg <= MCD_IDLE;
          end
        end
      endcase
    end
  end

  // result write back, one-cycle pulse
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      wb_valid_reg <= 1'b0;
      wb_data_reg  <= 16'h0000;
      wb_sel_reg   <= 3'h0;
    end
    else if (i_ce)
    begin
      wb_valid_reg <= 1'b0;
      if ((is_shrsi | is_shri) && (imm == 4'h0))
      begin
        wb_valid_reg <= 1'b1; // zero shift: value unchanged
        wb_data_reg  <= i_alu_operand;
        wb_sel_reg   <= i_instr[`MCD_OP1_LSB +: 3];
      end
      else if ((state_reg == MCD_SHIFTING) && (sh_cnt_reg == 4'h1))
      begin
        wb_valid_reg <= 1'b1;
        wb_data_reg  <= sh_val_next;
        wb_sel_reg   <= sh_sel_reg;
      end
    end
  end

  // condition flags of the right-shift family
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      flags_reg <= '0;
    end
    else if (i_ce)
    begin
      if ((is_shrsi | is_shri) && (imm == 4'h0))
      begin
        flags_reg <= '0;
      end
      else if ((state_reg == MCD_SHIFTING) && (sh_cnt_reg == 4'h1))
      begin
        flags_reg.shifted_out_flag <= sh_val_reg[0];
        flags_reg.shift_overflow_flag <=
          sh_arith_reg & (sh_loss_reg | sh_val_reg[0]);
        flags_reg.precision_loss_flag <=
          ~sh_arith_reg & (sh_loss_reg | sh_val_reg[0]);
      end
    end
  end

  // addressing, reference and control settings, one cycle each
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      cfg_reg.control_reg      <= `MCD_RST_CTRL;
      cfg_reg.base_from_index  <= 1'b0;
      cfg_reg.index_base_value <= 6'h00;
      cfg_reg.spi_from_index   <= 1'b0;
      cfg_reg.fb_ref_battery   <= 1'b0;
      cfg_reg.auto_diag_on     <= 1'b0;
      cfg_reg.conversion_enable <= 4'h0;
      cfg_reg.arith_mode       <= mcd_arith_t'(`MCD_RST_ARITH);
    end
    else if (i_ce)
    begin
      if (is_slab)
      begin
        cfg_reg.base_from_index <= i_instr[0];
      end
      if (is_stab)
      begin
        cfg_reg.index_base_value <= i_instr[5:0];
      end
      if (is_slsa)
      begin
        cfg_reg.spi_from_index <= i_instr[0];
      end
      if (is_slfbk && drive_ok)
      begin
        cfg_reg.fb_ref_battery <= i_instr[`MCD_REF_BIT];
        if (i_instr[1])
        begin
          cfg_reg.auto_diag_on <= i_instr[0];
        end
      end
      if (is_stadc && block_ok)
      begin
        cfg_reg.conversion_enable[tgt] <=
          i_instr[`MCD_ADCM_BIT];
      end
      if (is_stal)
      begin
        cfg_reg.arith_mode <= mcd_arith_t'(i_instr[1:0]);
      end
      if (bus_wr_ctrl)
      begin
        cfg_reg.control_reg <= hwdata[15:0];
      end
      if (is_stcrb) // instruction bit beats a bus write
      begin
        cfg_reg.control_reg[`MCD_CRB_BASE + i_instr[2:0]] <=
          i_instr[`MCD_LVL_BIT];
      end
    end
  end

  // bus address phase capture
  assign bus_addr_ok = hsel & hready & htrans[1];
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      bus_wr_reg   <= 1'b0;
      bus_addr_reg <= 8'h00;
    end
    else if (i_ce)
    begin
      if (hready)
      begin
        bus_wr_reg   <= bus_addr_ok & hwrite;
        bus_addr_reg <= haddr[7:0];
      end
    end
  end

  // bus data phase write strobes
  assign bus_wr_ctrl   = bus_wr_reg & (bus_addr_reg == `MCD_OFF_CTRL);
  assign bus_wr_rights = bus_wr_reg & (bus_addr_reg == `MCD_OFF_RIGHTS);

  // access rights register
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      rights_reg <= `MCD_RST_RIGHTS;
    end
    else if (i_ce && bus_wr_rights)
    begin
      rights_reg <= hwdata[7:0] & 8'hf1;
    end
  end

  // status word of the block's own state
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[1:0] = cfg_reg.arith_mode;
    status_word[2] = cfg_reg.base_from_index;
    status_word[3] = cfg_reg.spi_from_index;
    status_word[4] = cfg_reg.fb_ref_battery;
    status_word[5] = cfg_reg.auto_diag_on;
    status_word[9:6] = cfg_reg.conversion_enable;
    status_word[15:10] = cfg_reg.index_base_value;
    status_word[`MCD_ST_SB] = flags_reg.shifted_out_flag;
    status_word[`MCD_ST_MO] = flags_reg.shift_overflow_flag;
    status_word[`MCD_ST_ML] = flags_reg.precision_loss_flag;
    status_word[`MCD_ST_BUSY] = (state_reg == MCD_SHIFTING);
  end

  // read data registered at the address phase
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      rdata_reg <= 32'h0000_0000;
    end
    else if (i_ce && hready)
    begin
      rdata_reg <= 32'h0000_0000;
      if (bus_addr_ok && !hwrite)
      begin
        unique case (haddr[7:0])
          `MCD_OFF_RIGHTS: rdata_reg <= {24'h000000, rights_reg};
          `MCD_OFF_STATUS: rdata_reg <= status_word;
          `MCD_OFF_CTRL:   rdata_reg <= {16'h0000, cfg_reg.control_reg};
          default:         rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // bus answers: never waits, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  // datapath outputs
  assign o_busy      = (state_reg == MCD_SHIFTING);
  assign o_wb_valid  = wb_valid_reg;
  assign o_wb_sel    = wb_sel_reg;
  assign o_wb_data   = wb_data_reg;
  assign o_cfg       = cfg_reg;
  assign o_flags     = flags_reg;
  assign o_data_base = cfg_reg.base_from_index ?
                       i_alu_index_reg[5:0] :
                       cfg_reg.index_base_value;

  // mode decode for the alu: overflow always, clamp when saturating
  assign o_arith_signed   = ~cfg_reg.arith_mode[1];
  assign o_arith_saturate = cfg_reg.arith_mode[0];
endmodule
